// ### system_tick_down_counter.sv
`timescale 1ns/100ps
`default_nettype none
`include "tick_defines.svh"

module system_tick_down_counter
    import tick_pkg::*;
#(
    parameter int CNT_W = 24
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire tick_pkg::apb_req_t apb_req,
    output var  tick_pkg::apb_rsp_t apb_rsp,
    input  wire logic              deep_sleep_mode,
    input  wire logic              power_down_mode,
    output logic                   tick_pend,
    output logic                   irq
);
    import tick_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (CNT_W < 2 || CNT_W > 24) begin : g_bad_width
        $error("counter width must be 2 to 24");
    end

    // ------------------------------------------------------------
    // pin synchronisers for the power mode levels
    // ------------------------------------------------------------
    logic [1:0] sleep_meta_r;
    logic [1:0] sleep_meta_nxt;
    logic [1:0] sleep_sync_r;
    logic [1:0] sleep_sync_nxt;

    always_comb begin
        sleep_meta_nxt = {power_down_mode, deep_sleep_mode};
        sleep_sync_nxt = sleep_meta_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_meta_r <= 2'h0;
            sleep_sync_r <= 2'h0;
        end else begin
            sleep_meta_r <= sleep_meta_nxt;
            sleep_sync_r <= sleep_sync_nxt;
        end
    end

    logic halted;
    assign halted = |sleep_sync_r;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic access;
    logic wr_csr;
    logic rd_csr;
    logic wr_rld;
    logic wr_cur;
    logic wr_ien;
    logic wr_iclr;
    logic mapped;

    assign access  = apb_req.psel && apb_req.penable;
    assign wr_csr  = access && apb_req.pwrite && apb_req.paddr == `TICK_CSR_OFFSET;
    assign rd_csr  = access && !apb_req.pwrite && apb_req.paddr == `TICK_CSR_OFFSET;
    assign wr_rld  = access && apb_req.pwrite && apb_req.paddr == `TICK_RELOAD_OFFSET;
    assign wr_cur  = access && apb_req.pwrite && apb_req.paddr == `TICK_CURRENT_OFFSET;
    assign wr_ien  = access && apb_req.pwrite && apb_req.paddr == `TICK_IRQ_ENABLE_OFF;
    assign wr_iclr = access && apb_req.pwrite && apb_req.paddr == `TICK_IRQ_CLEAR_OFF;
    assign mapped  = apb_req.paddr == `TICK_CSR_OFFSET
                  || apb_req.paddr == `TICK_RELOAD_OFFSET
                  || apb_req.paddr == `TICK_CURRENT_OFFSET
                  || apb_req.paddr == `TICK_IRQ_STATUS_OFF
                  || apb_req.paddr == `TICK_IRQ_ENABLE_OFF
                  || apb_req.paddr == `TICK_IRQ_CLEAR_OFF;

    // ------------------------------------------------------------
    // counter core
    // ------------------------------------------------------------
    tick_ctrl_t        ctrl_r;
    tick_ctrl_t        ctrl_nxt;
    logic [CNT_W-1:0]  reload_r;
    logic [CNT_W-1:0]  reload_nxt;
    logic [CNT_W-1:0]  count_r;
    logic [CNT_W-1:0]  count_nxt;
    logic              flag_r;
    logic              flag_nxt;
    logic              pend_r;
    logic              pend_nxt;
    logic              hit_zero;
    logic              step;

    // reload of zero parks the counter: no further transitions happen
    assign step     = ctrl_r.enable && !halted;
    assign hit_zero = step && count_r == CNT_W'(1);

    always_comb begin
        ctrl_nxt   = ctrl_r;
        reload_nxt = reload_r;
        count_nxt  = count_r;
        flag_nxt   = flag_r;
        pend_nxt   = 1'b0;
        if (wr_csr) begin
            ctrl_nxt.enable     = apb_req.pwdata[`TICK_CSR_ENABLE_BIT];
            ctrl_nxt.exc_enable = apb_req.pwdata[`TICK_CSR_EXC_BIT];
        end
        if (wr_rld) begin
            reload_nxt = apb_req.pwdata[CNT_W-1:0];
        end
        if (step) begin
            if (count_r == '0) begin
                count_nxt = reload_r;
            end else begin
                count_nxt = count_r - CNT_W'(1);
            end
        end
        if (rd_csr) begin
            flag_nxt = 1'b0;
        end
        if (wr_cur) begin
            count_nxt = '0;
            flag_nxt  = 1'b0;
        end
        // a zero transition beats a read clear; a current write drops it
        if (hit_zero && !wr_cur) begin
            flag_nxt = 1'b1;
            pend_nxt = ctrl_r.exc_enable;
        end
    end

    // reload and count carry no reset: their value after reset is undefined
    always_ff @(posedge pclk) begin
        reload_r <= reload_nxt;
        count_r  <= count_nxt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= '0;
            flag_r <= 1'b0;
            pend_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            flag_r <= flag_nxt;
            pend_r <= pend_nxt;
        end
    end

    assign tick_pend = pend_r;

    // ------------------------------------------------------------
    // interrupt status, enable and clear
    // ------------------------------------------------------------
    logic [`TICK_IRQ_WIDTH-1:0] ists_r;
    logic [`TICK_IRQ_WIDTH-1:0] ists_nxt;
    logic [`TICK_IRQ_WIDTH-1:0] ien_r;
    logic [`TICK_IRQ_WIDTH-1:0] ien_nxt;
    logic [`TICK_IRQ_WIDTH-1:0] ievt;
    logic                       irq_r;
    logic                       irq_nxt;

    always_comb begin
        ievt = '0;
        ievt[`TICK_IRQ_ZERO_BIT]  = hit_zero && !wr_cur;
        ievt[`TICK_IRQ_WRCLR_BIT] = wr_cur;
        ien_nxt = wr_ien ? apb_req.pwdata[`TICK_IRQ_WIDTH-1:0] : ien_r;
        ists_nxt = ists_r;
        if (wr_iclr) begin
            ists_nxt = ists_nxt & ~apb_req.pwdata[`TICK_IRQ_WIDTH-1:0];
        end
        ists_nxt = ists_nxt | ievt;
        irq_nxt  = |(ists_nxt & ien_nxt);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ists_r <= '0;
            ien_r  <= '0;
            irq_r  <= 1'b0;
        end else begin
            ists_r <= ists_nxt;
            ien_r  <= ien_nxt;
            irq_r  <= irq_nxt;
        end
    end

    assign irq = irq_r;

    // ------------------------------------------------------------
    // read data: single access cycle, zero wait states
    // ------------------------------------------------------------
    apb_rsp_t rsp_r;
    apb_rsp_t rsp_nxt;

    always_comb begin
        rsp_nxt         = '0;
        rsp_nxt.pready  = apb_req.psel && !apb_req.penable;
        rsp_nxt.pslverr = apb_req.psel && !apb_req.penable && !mapped;
        if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
            unique case (apb_req.paddr)
                `TICK_CSR_OFFSET: begin
                    rsp_nxt.prdata[`TICK_CSR_ENABLE_BIT] = ctrl_r.enable;
                    rsp_nxt.prdata[`TICK_CSR_EXC_BIT]    = ctrl_r.exc_enable;
                    rsp_nxt.prdata[`TICK_CSR_CLKSEL_BIT] = 1'b1;
                    rsp_nxt.prdata[`TICK_CSR_FLAG_BIT]   = flag_nxt;
                end
                `TICK_RELOAD_OFFSET:  rsp_nxt.prdata[CNT_W-1:0] = reload_r;
                `TICK_CURRENT_OFFSET: rsp_nxt.prdata[CNT_W-1:0] = count_nxt;
                `TICK_IRQ_STATUS_OFF: rsp_nxt.prdata[`TICK_IRQ_WIDTH-1:0] = ists_nxt;
                `TICK_IRQ_ENABLE_OFF: rsp_nxt.prdata[`TICK_IRQ_WIDTH-1:0] = ien_r;
                default: rsp_nxt.prdata = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    assign apb_rsp = rsp_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_zero_hit;
        step && count_r == CNT_W'(1) && !wr_cur;
    endsequence

    sequence s_low_power;
        (deep_sleep_mode || power_down_mode) [*2];
    endsequence

    sequence s_rld_read;
        access && !apb_req.pwrite && apb_req.paddr == `TICK_RELOAD_OFFSET;
    endsequence

    sequence s_cur_read;
        access && !apb_req.pwrite && apb_req.paddr == `TICK_CURRENT_OFFSET;
    endsequence

    count_down_a: assert property (@(posedge pclk) disable iff (!presetn)
        step && count_r > CNT_W'(1) && !wr_cur |=> count_r == $past(count_r) - CNT_W'(1))
        else $error("counter did not step down");
    reload_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_zero_hit ##1 (step && !wr_cur && !wr_rld) |=> count_r == $past(reload_r))
        else $error("counter did not reload after zero");
    write_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cur |=> count_r == '0 && !flag_r)
        else $error("current write did not clear");
    flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_zero_hit |=> flag_r)
        else $error("flag not set at zero");
    read_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_csr && !hit_zero |=> !flag_r)
        else $error("flag survived a read");
    zero_park_a: assert property (@(posedge pclk) disable iff (!presetn)
        step && count_r == '0 && reload_r == '0 && !wr_cur |=> count_r == '0)
        else $error("zero reload did not park");
    sleep_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
        halted && !wr_cur |=> count_r == $past(count_r) && !tick_pend)
        else $error("counter moved while halted");
    pend_exc_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_zero_hit |=> tick_pend == $past(ctrl_r.exc_enable))
        else $error("tick pend wrong");
    pend_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cur |=> !tick_pend)
        else $error("current write pended tick");
    clk_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_csr |-> apb_rsp.pready && apb_rsp.prdata[`TICK_CSR_CLKSEL_BIT])
        else $error("clock select did not read one");
    reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        apb_rsp.pready |-> apb_rsp.prdata[31:24] == '0)
        else $error("reserved bits nonzero");
    flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        flag_r && !rd_csr && !wr_cur |=> flag_r)
        else $error("flag lost without a clear");
    ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_csr |=> ctrl_r.enable == $past(apb_req.pwdata[`TICK_CSR_ENABLE_BIT])
                && ctrl_r.exc_enable == $past(apb_req.pwdata[`TICK_CSR_EXC_BIT]))
        else $error("control write not taken");
    reload_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_rld |=> reload_r == $past(apb_req.pwdata[CNT_W-1:0]))
        else $error("reload write not taken");
    pend_single_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick_pend |=> !tick_pend)
        else $error("tick pend longer than one cycle");
    pend_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick_pend |-> $past(hit_zero) && !$past(wr_cur) && $past(ctrl_r.exc_enable))
        else $error("tick pended without a zero hit");
    zero_status_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_zero_hit |=> ists_r[`TICK_IRQ_ZERO_BIT])
        else $error("zero status not set");
    sleep_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_low_power |=> halted)
        else $error("low power not seen after sync");

    // ------------------------------------------------------------
    // bus response checks
    // ------------------------------------------------------------
    ready_access_a: assert property (@(posedge pclk) disable iff (!presetn)
        access |-> apb_rsp.pready)
        else $error("access cycle without ready");
    ready_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        apb_rsp.pready |-> access)
        else $error("ready outside an access cycle");
    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        access && !mapped |-> apb_rsp.pslverr && apb_rsp.prdata == '0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
        access && mapped |-> !apb_rsp.pslverr)
        else $error("mapped access refused");
    csr_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_csr |-> apb_rsp.prdata[31:17] == '0 && apb_rsp.prdata[15:3] == '0)
        else $error("control reserved bits nonzero");
    csr_fields_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_csr |-> apb_rsp.prdata[`TICK_CSR_FLAG_BIT] == flag_r
                && apb_rsp.prdata[`TICK_CSR_ENABLE_BIT] == ctrl_r.enable
                && apb_rsp.prdata[`TICK_CSR_EXC_BIT] == ctrl_r.exc_enable)
        else $error("control read fields wrong");
    reload_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_rld_read |-> apb_rsp.prdata == 32'(reload_r))
        else $error("reload read wrong");
    current_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_cur_read |-> apb_rsp.prdata == 32'(count_r))
        else $error("current read not live");

endmodule
`default_nettype wire

// ### tick_defines.svh
`ifndef TICK_DEFINES_SVH
`define TICK_DEFINES_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define TICK_BASE_ADDR       32'he000_e000
`define TICK_CSR_OFFSET      12'h010
`define TICK_RELOAD_OFFSET   12'h014
`define TICK_CURRENT_OFFSET  12'h018
`define TICK_IRQ_STATUS_OFF  12'h020
`define TICK_IRQ_ENABLE_OFF  12'h024
`define TICK_IRQ_CLEAR_OFF   12'h028

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define TICK_CSR_ENABLE_BIT  0
`define TICK_CSR_EXC_BIT     1
`define TICK_CSR_CLKSEL_BIT  2
`define TICK_CSR_FLAG_BIT    16
`define TICK_CSR_RESET       32'h0000_0004
`define TICK_IRQ_ZERO_BIT    0
`define TICK_IRQ_WRCLR_BIT   1
`define TICK_IRQ_WIDTH       2

`endif

// ### tick_pkg.sv
package tick_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic enable;
        logic exc_enable;
    } tick_ctrl_t;

endpackage

// ### system_tick_down_counter_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "tick_defines.svh"

module system_tick_down_counter_bench;
    import tick_pkg::*;

    // ------------------------------------------------------------
    // clock, reset and design
    // ------------------------------------------------------------
    localparam logic [11:0] off_csr = `TICK_CSR_OFFSET;
    localparam logic [11:0] off_rld = `TICK_RELOAD_OFFSET;
    localparam logic [11:0] off_cur = `TICK_CURRENT_OFFSET;
    localparam logic [11:0] off_sts = `TICK_IRQ_STATUS_OFF;
    localparam logic [11:0] off_ien = `TICK_IRQ_ENABLE_OFF;
    localparam logic [11:0] off_clr = `TICK_IRQ_CLEAR_OFF;

    logic        pclk            = 1'b0;
    logic        presetn         = 1'b0;
    apb_req_t    req             = '0;
    apb_rsp_t    rsp;
    logic        deep_sleep_mode = 1'b0;
    logic        power_down_mode = 1'b0;
    logic        tick_pend;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          fail_count      = 0;
    int          comparisons     = 0;
    int          cycles          = 0;

    always #50 pclk = ~pclk;

    system_tick_down_counter #(.CNT_W(24)) dut (
        .pclk            (pclk),
        .presetn         (presetn),
        .apb_req         (req),
        .apb_rsp         (rsp),
        .deep_sleep_mode (deep_sleep_mode),
        .power_down_mode (power_down_mode),
        .tick_pend       (tick_pend),
        .irq             (irq)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= a;
        req.pwdata  <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        rd  = rsp.prdata;
        err = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wait_pend(output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (tick_pend !== 1'b1 && n < 200);
        chk({31'h0, tick_pend}, 32'h1);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic reset_values;
        apb(1'b0, off_csr, 32'h0);
        chk(rd, `TICK_CSR_RESET);
        apb(1'b1, off_csr, 32'h0);
        apb(1'b0, off_csr, 32'h0);
        chk(rd, 32'h0000_0004);
        apb(1'b0, 12'h01c, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask

    task automatic period_and_flag;
        int          n;
        logic [31:0] a;
        apb(1'b1, off_rld, 32'hff00_0028);
        apb(1'b0, off_rld, 32'h0);
        chk(rd, 32'h0000_0028);
        apb(1'b1, off_cur, 32'h1234_5678);
        apb(1'b0, off_cur, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, off_csr, 32'h0000_0003);
        wait_pend(n);
        wait_pend(n);
        chk(n, 32'd41);
        apb(1'b0, off_csr, 32'h0);
        chk(rd, 32'h0001_0007);
        apb(1'b0, off_csr, 32'h0);
        chk(rd, 32'h0000_0007);
        apb(1'b0, off_cur, 32'h0);
        a = rd;
        apb(1'b0, off_cur, 32'h0);
        chk({31'h0, a <= 32'd40}, 32'h1);
        if (a >= 32'd3) begin
            chk(a - rd, 32'd3);
        end
        wait_pend(n);
        apb(1'b1, off_cur, 32'h0);
        apb(1'b0, off_csr, 32'h0);
        chk(rd, 32'h0000_0007);
    endtask

    // status, enable and clear of the interrupt output
    task automatic interrupts;
        int n;
        apb(1'b1, off_clr, 32'h3);
        apb(1'b1, off_ien, 32'h1);
        wait_pend(n);
        apb(1'b0, off_sts, 32'h0);
        chk(rd, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, off_ien, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, off_clr, 32'h1);
        apb(1'b1, off_cur, 32'h0);
        apb(1'b1, off_sts, 32'h0);
        apb(1'b0, off_sts, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, off_ien, 32'h2);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, off_clr, 32'h2);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic zero_reload;
        apb(1'b1, off_rld, 32'h0);
        apb(1'b1, off_cur, 32'h0);
        apb(1'b0, off_csr, 32'h0);
        repeat (20) @(posedge pclk);
        apb(1'b0, off_cur, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, off_csr, 32'h0);
        chk(rd, 32'h0000_0007);
    endtask

    // both low-power inputs must freeze the live count
    task automatic halt_modes;
        logic [31:0] a;
        apb(1'b1, off_rld, 32'h0000_0028);
        apb(1'b1, off_cur, 32'h0);
        for (int i = 0; i < 2; i++) begin
            @(posedge pclk);
            deep_sleep_mode <= (i == 0);
            power_down_mode <= (i == 1);
            repeat (4) @(posedge pclk);
            apb(1'b0, off_cur, 32'h0);
            a = rd;
            repeat (10) @(posedge pclk);
            apb(1'b0, off_cur, 32'h0);
            chk(rd, a);
            deep_sleep_mode <= 1'b0;
            power_down_mode <= 1'b0;
        end
    endtask

    // exception enable off: the flag still sets, nothing is pended
    task automatic quiet_count;
        int seen;
        seen = 0;
        apb(1'b1, off_rld, 32'h0000_0009);
        apb(1'b1, off_cur, 32'h0);
        apb(1'b1, off_csr, 32'h0000_0001);
        apb(1'b0, off_csr, 32'h0);
        repeat (30) begin
            @(posedge pclk);
            if (tick_pend !== 1'b0) begin
                seen++;
            end
        end
        chk(seen, 32'h0);
        apb(1'b0, off_csr, 32'h0);
        chk(rd, 32'h0001_0005);
    endtask

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            complete_run();
        end
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        reset_values();
        period_and_flag();
        interrupts();
        zero_reload();
        halt_modes();
        quiet_count();
        complete_run();
    end

endmodule

`default_nettype wire
